// File: rtl/achi_pkg.sv
// Purpose: Shared constants and types of the call handling interpreter.
// Assumes: Registers sit on a plain 32-bit port; one clock.
// Notes: Digits are packed as eight 4-bit codes, all-zero meaning blank.
package achi_pkg;
    localparam int SLOTS = 10;
    localparam int PORTS = 4;
    localparam int NUM_W = 32;
    localparam logic [3:0] SLOT_LAST = 4'h9;
    localparam logic [1:0] ESC_COUNT = 2'h3;
    localparam logic [7:0] ESC_CHAR = 8'h2B;

    // Register byte addresses.
    localparam logic [7:0] REG_AUTO = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_DIR0 = 8'h08;
    localparam logic [7:0] REG_DIR1 = 8'h0C;
    localparam logic [7:0] REG_DIR2 = 8'h10;
    localparam logic [7:0] REG_DIR3 = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    // Field positions and reset values.
    localparam int CFG_IGN_DTR = 0;
    localparam int ST_PEND = 2;
    localparam int ST_PORT = 4;
    localparam int ST_RINGS = 8;
    localparam logic [7:0] AUTO_RESET = 8'h00;
    localparam logic IGN_DTR_RESET = 1'b0;
    localparam logic [31:0] DIR_RESET = 32'h0000_0000;

    // Result codes, terse numbering; NUMBER reports a stored slot.
    localparam logic [3:0] RES_OK = 4'h0;
    localparam logic [3:0] RES_CONNECT = 4'h1;
    localparam logic [3:0] RES_RING = 4'h2;
    localparam logic [3:0] RES_NO_CARRIER = 4'h3;
    localparam logic [3:0] RES_ERROR = 4'h4;
    localparam logic [3:0] RES_BUSY = 4'h7;
    localparam logic [3:0] RES_NUMBER = 4'hF;

    typedef enum logic [1:0] {
        MODE_OFFLINE = 2'b00,
        MODE_DIALING = 2'b01,
        MODE_DATA = 2'b10,
        MODE_ONLINE_CMD = 2'b11
    } achi_mode_e;

    typedef enum logic [3:0] {
        CMD_ATTENTION = 4'h0,
        CMD_STORE = 4'h1,
        CMD_SHOW = 4'h2,
        CMD_LIST = 4'h3,
        CMD_DIAL_STORED = 4'h4,
        CMD_ANSWER = 4'h5,
        CMD_HANGUP = 4'h6,
        CMD_ESC_HANGUP = 4'h7,
        CMD_RETURN_ONLINE = 4'h8
    } achi_cmd_e;
endpackage

// File: rtl/achi_port_match.sv
// Purpose: Tells whether one port may take a call to a called number.
// Assumes: A directory number of all zeros is blank.
// Notes: Purely combinational; one instance per port.
`timescale 1ns/10ps
module achi_port_match (
    // Port setting and state
    input wire logic [achi_pkg::NUM_W-1:0] dirNumber,
    input wire logic busy,
    // Incoming call
    input wire logic [achi_pkg::NUM_W-1:0] calledNumber,
    // Eligibility
    output logic matchFree,
    output logic blankFree
);
    logic blank;

    assign blank = (dirNumber == '0);
    assign matchFree = !busy && !blank && (dirNumber == calledNumber);
    assign blankFree = !busy && blank;
endmodule // achi_port_match

// File: rtl/achi_interpreter.sv
// Purpose: Command and call handling core of the terminal adapter.
// Assumes: Commands arrive decoded, one per cmdValid pulse; inputs are synchronous.
// Notes: Notes on behaviour
// Notes on behaviour
// - Host character cancels unfinished outgoing call.
// - Store command saves dial string in slot.
// - Dial-stored command dials the slot's number.
// - Show command reports one slot's string.
// - Ten slots; list reports all of them.
// - Incoming call raises ring indicator, RING each.
// - Answer command answers pending incoming call.
// - Offline autoanswer on ring matching setting.
// - Ring setting zero disables autoanswer.
// - Without ignore-DTR, calls need DTR high.
// - Blank directory number accepts any called number.
// - Matching directory number beats blank one.
// - Busy match falls to other free eligible.
// - No eligible free port rejects with busy.
// - Ports ordered data1, data2, modem1, modem2.
// - Escape then hang-up, or both combined.
// - Bare attention command answers OK.
// - Data mode passes host text through.
// - Return-online resumes data mode.
`timescale 1ns/10ps
module achi_interpreter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Decoded host commands
    input wire logic cmdValid,
    input wire achi_pkg::achi_cmd_e cmdOp,
    input wire logic [3:0] cmdIndex,
    input wire logic [achi_pkg::NUM_W-1:0] cmdNumber,
    output logic cmdReady,
    // Raw host characters
    input wire logic hostCharValid,
    input wire logic [7:0] hostChar,
    input wire logic dtr,
    // Results to host
    output logic resultValid,
    output logic [3:0] resultCode,
    output logic [3:0] resultSlot,
    output logic [achi_pkg::NUM_W-1:0] resultNumber,
    output logic ringResult,
    output logic ringIndicator,
    // Line side
    input wire logic linkUp,
    input wire logic callArrive,
    input wire logic [achi_pkg::NUM_W-1:0] calledNumber,
    input wire logic ringIn,
    input wire logic callGone,
    input wire logic [achi_pkg::PORTS-1:0] portBusy,
    output logic dialReq,
    output logic [achi_pkg::NUM_W-1:0] dialNumber,
    output logic answerReq,
    output logic hangupReq,
    output logic busyReject,
    output logic [1:0] routedPort,
    output logic remoteValid,
    output logic [7:0] remoteChar
);
    achi_pkg::achi_mode_e mode_q, mode_d;
    logic [achi_pkg::NUM_W-1:0] mem_q [achi_pkg::SLOTS], mem_d [achi_pkg::SLOTS];
    logic [achi_pkg::NUM_W-1:0] dir_q [achi_pkg::PORTS], dir_d [achi_pkg::PORTS];
    logic [7:0] autoRings_q, autoRings_d, ringCount_q, ringCount_d;
    logic ignDtr_q, ignDtr_d, pending_q, pending_d, listing_q, listing_d;
    logic [3:0] listIdx_q, listIdx_d;
    logic [1:0] plus_q, plus_d, port_q, port_d;
    logic [31:0] rdata_q, rdata_d;
    logic resV_q, resV_d, ring_q, ring_d, dial_q, dial_d, ans_q, ans_d;
    logic hang_q, hang_d, busy_q, busy_d, remV_q, remV_d;
    logic [3:0] resCode_q, resCode_d, resSlot_q, resSlot_d;
    logic [achi_pkg::NUM_W-1:0] resNum_q, resNum_d, dialNum_q, dialNum_d;
    logic [7:0] remChar_q, remChar_d;
    logic [achi_pkg::PORTS-1:0] matchFree, blankFree;
    logic routeOk;
    logic [1:0] routePort;
    logic idxOk, autoHit;
    logic ready_q, ready_d;

    // One matcher per port, in data1, data2, modem1, modem2 order.
    for (genvar p = 0; p < achi_pkg::PORTS; p++) begin : g_match
        achi_port_match u_match (
            .dirNumber(dir_q[p]),
            .busy(portBusy[p]),
            .calledNumber(calledNumber),
            .matchFree(matchFree[p]),
            .blankFree(blankFree[p])
        );
    end

    // Lowest free match first, otherwise lowest free blank port.
    always_comb begin
        routeOk = 1'b0;
        routePort = 2'h0;
        for (int p = achi_pkg::PORTS - 1; p >= 0; p--) begin
            if (blankFree[p]) begin
                routeOk = 1'b1;
                routePort = 2'(p);
            end
        end
        for (int p = achi_pkg::PORTS - 1; p >= 0; p--) begin
            if (matchFree[p]) begin
                routeOk = 1'b1;
                routePort = 2'(p);
            end
        end
    end

    assign idxOk = (cmdIndex <= achi_pkg::SLOT_LAST);
    assign autoHit = pending_q && ringIn && (autoRings_q != 8'h00)
        && (ringCount_q + 8'h01 == autoRings_q) && (mode_q == achi_pkg::MODE_OFFLINE);

    always_comb begin
        mode_d = mode_q;
        mem_d = mem_q;
        dir_d = dir_q;
        autoRings_d = autoRings_q;
        ignDtr_d = ignDtr_q;
        ringCount_d = ringCount_q;
        pending_d = pending_q;
        listing_d = listing_q;
        listIdx_d = listIdx_q;
        plus_d = plus_q;
        port_d = port_q;
        rdata_d = rdata_q;
        resV_d = 1'b0;
        resCode_d = resCode_q;
        resSlot_d = resSlot_q;
        resNum_d = resNum_q;
        ring_d = 1'b0;
        dial_d = 1'b0;
        dialNum_d = dialNum_q;
        ans_d = 1'b0;
        hang_d = 1'b0;
        busy_d = 1'b0;
        remV_d = 1'b0;
        remChar_d = remChar_q;

        // Register port; unmapped addresses read zero.
        if (regWrite) begin
            unique case (regAddr)
                achi_pkg::REG_AUTO: autoRings_d = regWdata[7:0];
                achi_pkg::REG_CFG: ignDtr_d = regWdata[achi_pkg::CFG_IGN_DTR];
                achi_pkg::REG_DIR0: dir_d[0] = regWdata;
                achi_pkg::REG_DIR1: dir_d[1] = regWdata;
                achi_pkg::REG_DIR2: dir_d[2] = regWdata;
                achi_pkg::REG_DIR3: dir_d[3] = regWdata;
                default: ;
            endcase
        end
        rdata_d = 32'h0000_0000;
        if (regRead) begin
            unique case (regAddr)
                achi_pkg::REG_AUTO: rdata_d[7:0] = autoRings_q;
                achi_pkg::REG_CFG: rdata_d[achi_pkg::CFG_IGN_DTR] = ignDtr_q;
                achi_pkg::REG_DIR0: rdata_d = dir_q[0];
                achi_pkg::REG_DIR1: rdata_d = dir_q[1];
                achi_pkg::REG_DIR2: rdata_d = dir_q[2];
                achi_pkg::REG_DIR3: rdata_d = dir_q[3];
                achi_pkg::REG_STATUS: begin
                    rdata_d[1:0] = mode_q;
                    rdata_d[achi_pkg::ST_PEND] = pending_q;
                    rdata_d[achi_pkg::ST_PORT +: 2] = port_q;
                    rdata_d[achi_pkg::ST_RINGS +: 8] = ringCount_q;
                end
                default: ;
            endcase
        end

        // Host characters: cancel a dial, or pass data and watch for escape.
        if (hostCharValid) begin
            if (mode_q == achi_pkg::MODE_DIALING) begin
                mode_d = achi_pkg::MODE_OFFLINE;
                hang_d = 1'b1;
                resV_d = 1'b1;
                resCode_d = achi_pkg::RES_NO_CARRIER;
            end else if (mode_q == achi_pkg::MODE_DATA) begin
                remV_d = 1'b1;
                remChar_d = hostChar;
                if (hostChar == achi_pkg::ESC_CHAR) begin
                    plus_d = plus_q + 2'h1;
                    if (plus_q + 2'h1 == achi_pkg::ESC_COUNT) begin
                        mode_d = achi_pkg::MODE_ONLINE_CMD;
                        plus_d = 2'h0;
                    end
                end else begin
                    plus_d = 2'h0;
                end
            end
        end
        if (mode_q == achi_pkg::MODE_DIALING && linkUp && !hostCharValid) begin
            mode_d = achi_pkg::MODE_DATA;
            resV_d = 1'b1;
            resCode_d = achi_pkg::RES_CONNECT;
        end

        // Listing walks every slot, one report a cycle.
        if (listing_q) begin
            resV_d = 1'b1;
            resCode_d = achi_pkg::RES_NUMBER;
            resSlot_d = listIdx_q;
            resNum_d = mem_q[listIdx_q];
            listIdx_d = listIdx_q + 4'h1;
            listing_d = (listIdx_q != achi_pkg::SLOT_LAST);
        end else if (cmdValid && (mode_q == achi_pkg::MODE_OFFLINE
                || mode_q == achi_pkg::MODE_ONLINE_CMD
                || (mode_q == achi_pkg::MODE_DATA && cmdOp == achi_pkg::CMD_ESC_HANGUP))) begin
            resV_d = 1'b1;
            resCode_d = achi_pkg::RES_OK;
            unique case (cmdOp)
                achi_pkg::CMD_ATTENTION: ;
                achi_pkg::CMD_STORE: begin
                    if (idxOk) mem_d[cmdIndex] = cmdNumber;
                    else resCode_d = achi_pkg::RES_ERROR;
                end
                achi_pkg::CMD_SHOW: begin
                    if (idxOk) begin
                        resCode_d = achi_pkg::RES_NUMBER;
                        resSlot_d = cmdIndex;
                        resNum_d = mem_q[cmdIndex];
                    end else begin
                        resCode_d = achi_pkg::RES_ERROR;
                    end
                end
                achi_pkg::CMD_LIST: begin
                    resV_d = 1'b0;
                    listing_d = 1'b1;
                    listIdx_d = 4'h0;
                end
                achi_pkg::CMD_DIAL_STORED: begin
                    if (idxOk && mode_q == achi_pkg::MODE_OFFLINE) begin
                        resV_d = 1'b0;
                        mode_d = achi_pkg::MODE_DIALING;
                        dial_d = 1'b1;
                        dialNum_d = mem_q[cmdIndex];
                    end else begin
                        resCode_d = achi_pkg::RES_ERROR;
                    end
                end
                achi_pkg::CMD_ANSWER: begin
                    if (pending_q && mode_q == achi_pkg::MODE_OFFLINE) begin
                        mode_d = achi_pkg::MODE_DATA;
                        ans_d = 1'b1;
                        pending_d = 1'b0;
                        ringCount_d = 8'h00;
                        resCode_d = achi_pkg::RES_CONNECT;
                    end else begin
                        resCode_d = achi_pkg::RES_ERROR;
                    end
                end
                achi_pkg::CMD_HANGUP, achi_pkg::CMD_ESC_HANGUP: begin
                    hang_d = (mode_q != achi_pkg::MODE_OFFLINE);
                    mode_d = achi_pkg::MODE_OFFLINE;
                    plus_d = 2'h0;
                end
                achi_pkg::CMD_RETURN_ONLINE: begin
                    if (mode_q == achi_pkg::MODE_ONLINE_CMD) begin
                        mode_d = achi_pkg::MODE_DATA;
                        resCode_d = achi_pkg::RES_CONNECT;
                    end else begin
                        resCode_d = achi_pkg::RES_ERROR;
                    end
                end
                default: resCode_d = achi_pkg::RES_ERROR;
            endcase
        end

        // Incoming calls; a new arrival is ignored while one is pending.
        if (callArrive && !pending_q) begin
            if ((ignDtr_q || dtr) && routeOk) begin
                pending_d = 1'b1;
                port_d = routePort;
                ringCount_d = 8'h00;
            end else begin
                busy_d = 1'b1;
            end
        end else if (pending_q && callGone) begin
            pending_d = 1'b0;
            ringCount_d = 8'h00;
        end else if (pending_q && ringIn) begin
            ring_d = 1'b1;
            ringCount_d = ringCount_q + 8'h01;
            if (autoHit) begin
                mode_d = achi_pkg::MODE_DATA;
                ans_d = 1'b1;
                pending_d = 1'b0;
                ringCount_d = 8'h00;
            end
        end
        ready_d = !listing_d;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= achi_pkg::MODE_OFFLINE;
            for (int i = 0; i < achi_pkg::SLOTS; i++) mem_q[i] <= 32'h0000_0000;
            for (int i = 0; i < achi_pkg::PORTS; i++) dir_q[i] <= achi_pkg::DIR_RESET;
            autoRings_q <= achi_pkg::AUTO_RESET;
            ignDtr_q <= achi_pkg::IGN_DTR_RESET;
            ringCount_q <= 8'h00;
            pending_q <= 1'b0;
            listing_q <= 1'b0;
            listIdx_q <= 4'h0;
            plus_q <= 2'h0;
            port_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
            resV_q <= 1'b0;
            resCode_q <= achi_pkg::RES_OK;
            resSlot_q <= 4'h0;
            resNum_q <= 32'h0000_0000;
            ring_q <= 1'b0;
            dial_q <= 1'b0;
            dialNum_q <= 32'h0000_0000;
            ans_q <= 1'b0;
            hang_q <= 1'b0;
            busy_q <= 1'b0;
            remV_q <= 1'b0;
            remChar_q <= 8'h00;
            ready_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            mem_q <= mem_d;
            dir_q <= dir_d;
            autoRings_q <= autoRings_d;
            ignDtr_q <= ignDtr_d;
            ringCount_q <= ringCount_d;
            pending_q <= pending_d;
            listing_q <= listing_d;
            listIdx_q <= listIdx_d;
            plus_q <= plus_d;
            port_q <= port_d;
            rdata_q <= rdata_d;
            resV_q <= resV_d;
            resCode_q <= resCode_d;
            resSlot_q <= resSlot_d;
            resNum_q <= resNum_d;
            ring_q <= ring_d;
            dial_q <= dial_d;
            dialNum_q <= dialNum_d;
            ans_q <= ans_d;
            hang_q <= hang_d;
            busy_q <= busy_d;
            remV_q <= remV_d;
            remChar_q <= remChar_d;
            ready_q <= ready_d;
        end
    end

    assign regRdata = rdata_q;
    assign cmdReady = ready_q;
    assign resultValid = resV_q;
    assign resultCode = resCode_q;
    assign resultSlot = resSlot_q;
    assign resultNumber = resNum_q;
    assign ringResult = ring_q;
    assign ringIndicator = pending_q;
    assign dialReq = dial_q;
    assign dialNumber = dialNum_q;
    assign answerReq = ans_q;
    assign hangupReq = hang_q;
    assign busyReject = busy_q;
    assign routedPort = port_q;
    assign remoteValid = remV_q;
    assign remoteChar = remChar_q;

    sequence dialing_s;
        mode_q == achi_pkg::MODE_DIALING;
    endsequence
    sequence list_cmd_s;
        cmdValid && cmdReady && cmdOp == achi_pkg::CMD_LIST
            && (mode_q == achi_pkg::MODE_OFFLINE || mode_q == achi_pkg::MODE_ONLINE_CMD);
    endsequence

    dial_cancel_a: assert property (@(posedge clk) disable iff (rst)
        dialing_s ##0 hostCharValid |=> mode_q == achi_pkg::MODE_OFFLINE && hangupReq)
        else $error("Host character did not cancel the dial.");
    store_slot_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdReady && cmdOp == achi_pkg::CMD_STORE && idxOk
            && mode_q == achi_pkg::MODE_OFFLINE |=> mem_q[$past(cmdIndex)] == $past(cmdNumber))
        else $error("Stored number not written.");
    dial_stored_a: assert property (@(posedge clk) disable iff (rst)
        dialReq |-> (dialNumber == mem_q[$past(cmdIndex)]) and dialing_s)
        else $error("Dialed number differs from slot.");
    list_all_a: assert property (@(posedge clk) disable iff (rst)
        list_cmd_s |=> ##1 (resultValid && resultCode == achi_pkg::RES_NUMBER) [*8]
            ##1 resultValid ##1 resultValid && resultSlot == 4'h9 ##1 !listing_q)
        else $error("List did not report ten slots.");
    ring_report_a: assert property (@(posedge clk) disable iff (rst)
        pending_q && ringIn && !callGone && !callArrive |=> ringResult && $past(ringIndicator))
        else $error("Ring not reported.");
    auto_off_a: assert property (@(posedge clk) disable iff (rst)
        autoRings_q == 8'h00 && !(cmdValid && cmdOp == achi_pkg::CMD_ANSWER) |=> !answerReq)
        else $error("Answered with autoanswer disabled.");
    dtr_gate_a: assert property (@(posedge clk) disable iff (rst)
        callArrive && !pending_q && !ignDtr_q && !dtr |=> busyReject && !ringIndicator)
        else $error("Call accepted while DTR low.");
    route_busy_a: assert property (@(posedge clk) disable iff (rst)
        callArrive && !pending_q && (matchFree | blankFree) == 4'h0 |=> busyReject)
        else $error("No free port but no busy reject.");
    ring_clear_a: assert property (@(posedge clk) disable iff (rst)
        answerReq |-> ringCount_q == 8'h00 && !ringIndicator)
        else $error("Ring count not cleared on answer.");
endmodule // achi_interpreter

// File: bench/achi_host_model.sv
// Purpose: Host terminal model that types characters to the interpreter.
// Assumes: One character per transfer, held for a single clock cycle.
// Notes: Between characters the line shows the inverse of the last one, never a stale copy.
`timescale 1ns/10ps
module achi_host_model (
    // Clock
    input wire logic clk,
    // Character line
    output logic hostCharValid,
    output logic [7:0] hostChar
);
    initial begin
        hostCharValid = 1'h0;
        hostChar = 8'h00;
    end
    task automatic send(input logic [7:0] c);
        @(posedge clk);
        hostCharValid <= 1'h1;
        hostChar <= c;
        @(posedge clk);
        hostCharValid <= 1'h0;
        hostChar <= ~c;
        #1;
    endtask
    // A host types no faster than one character every other cycle, so pluses never abut.
    task automatic escape;
        repeat (3) send(achi_pkg::ESC_CHAR);
    endtask
endmodule // achi_host_model

// File: bench/at_call_handling_interpreter_bench.sv
// Purpose: Self-checking bench of the call handling interpreter.
// Assumes: Host characters come from the host model; all other inputs are driven here.
// Notes: Dial strings come from a fixed seed; expected values are kept in bench state.
`timescale 1ns/10ps
module at_call_handling_interpreter_bench;
    logic clk, rst, regWrite, regRead, cmdValid, dtr, linkUp, callArrive, ringIn, callGone;
    logic [7:0] regAddr, hostChar, remoteChar;
    logic [31:0] regWdata, regRdata, calledNumber, cmdNumber, dialNumber, resultNumber;
    achi_pkg::achi_cmd_e cmdOp;
    logic [3:0] cmdIndex, resultCode, resultSlot, portBusy, idx;
    logic cmdReady, hostCharValid, resultValid, ringResult, ringIndicator, remoteValid;
    logic dialReq, answerReq, hangupReq, busyReject;
    logic [1:0] routedPort;
    logic [31:0] mem [10];
    logic [31:0] seed, numA;
    int errorCnt = 0, testsRun = 0, cycles = 0;

    achi_interpreter u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdIndex(cmdIndex), .cmdNumber(cmdNumber), .cmdReady(cmdReady),
        .hostCharValid(hostCharValid), .hostChar(hostChar), .dtr(dtr),
        .resultValid(resultValid), .resultCode(resultCode), .resultSlot(resultSlot),
        .resultNumber(resultNumber), .ringResult(ringResult), .ringIndicator(ringIndicator),
        .linkUp(linkUp), .callArrive(callArrive), .calledNumber(calledNumber), .ringIn(ringIn),
        .callGone(callGone), .portBusy(portBusy), .dialReq(dialReq), .dialNumber(dialNumber),
        .answerReq(answerReq), .hangupReq(hangupReq), .busyReject(busyReject),
        .routedPort(routedPort), .remoteValid(remoteValid), .remoteChar(remoteChar));
    achi_host_model u_host (.clk(clk), .hostCharValid(hostCharValid), .hostChar(hostChar));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic regChk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge clk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'h0;
        #1 chk(regRdata & mask, exp);
    endtask
    task automatic doCmd(input achi_pkg::achi_cmd_e op, input logic [3:0] i,
            input logic [31:0] n);
        @(posedge clk);
        cmdValid <= 1'h1;
        cmdOp <= op;
        cmdIndex <= i;
        cmdNumber <= n;
        @(posedge clk);
        cmdValid <= 1'h0;
        #1;
    endtask
    task automatic res(input logic [3:0] code);
        chk(resultValid, 1'h1);
        chk(resultCode, code);
    endtask
    // Kind 0 call arrival, 1 ring, 2 call gone, 3 outgoing link up.
    task automatic linePulse(input int k, input logic [31:0] n);
        @(posedge clk);
        calledNumber <= n;
        callArrive <= (k == 0);
        ringIn <= (k == 1);
        callGone <= (k == 2);
        linkUp <= (k == 3);
        @(posedge clk);
        {callArrive, ringIn, callGone, linkUp} <= 4'h0;
        #1;
    endtask
    task automatic hangUp;
        u_host.escape;
        doCmd(achi_pkg::CMD_HANGUP, 4'h0, 32'h0);
        res(achi_pkg::RES_OK);
        chk(hangupReq, 1'h1);
        regChk(achi_pkg::REG_STATUS, 32'h3, 32'h0);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errorCnt++;
            report_and_stop;
        end
    end

    initial begin
        seed = 32'hB242C096;
        {rst, dtr} = 2'h3;
        {regWrite, regRead, cmdValid, linkUp, callArrive, ringIn, callGone} = 7'h00;
        {regAddr, regWdata, cmdIndex, cmdNumber, calledNumber, portBusy} = 'h0;
        cmdOp = achi_pkg::CMD_ATTENTION;
        numA = $random(seed) | 32'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        regChk(achi_pkg::REG_AUTO, 32'hFFFF_FFFF, 32'h0);
        regChk(achi_pkg::REG_CFG, 32'hFFFF_FFFF, 32'h0);
        regChk(achi_pkg::REG_DIR0, 32'hFFFF_FFFF, 32'h0);
        regChk(achi_pkg::REG_STATUS, 32'hFFFF_FFFF, 32'h0);
        regChk(8'hFC, 32'hFFFF_FFFF, 32'h0);
        chk(cmdReady, 1'h1);
        $display("test reset done");
        doCmd(achi_pkg::CMD_ATTENTION, 4'h0, 32'h0);
        res(achi_pkg::RES_OK);
        for (int i = 0; i < 10; i++) begin
            mem[i] = $random(seed);
            doCmd(achi_pkg::CMD_STORE, 4'(i), mem[i]);
            res(achi_pkg::RES_OK);
        end
        doCmd(achi_pkg::CMD_STORE, 4'hA, 32'hFFFF_FFFF);
        res(achi_pkg::RES_ERROR);
        repeat (4) begin
            idx = 4'($unsigned($random(seed)) % 10);
            doCmd(achi_pkg::CMD_SHOW, idx, 32'h0);
            res(achi_pkg::RES_NUMBER);
            chk(resultSlot, idx);
            chk(resultNumber, mem[idx]);
        end
        doCmd(achi_pkg::CMD_LIST, 4'h0, 32'h0);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 res(achi_pkg::RES_NUMBER);
            chk(resultSlot, 32'(i));
            chk(cmdReady, 32'(i == 9));
            chk(resultNumber, mem[i]);
        end
        repeat (2) @(posedge clk);
        $display("test memory done");
        doCmd(achi_pkg::CMD_DIAL_STORED, 4'h3, 32'h0);
        chk(dialReq, 1'h1);
        chk(dialNumber, mem[3]);
        u_host.send(8'h41);
        res(achi_pkg::RES_NO_CARRIER);
        chk(hangupReq, 1'h1);
        doCmd(achi_pkg::CMD_DIAL_STORED, 4'h7, 32'h0);
        linePulse(3, 32'h0);
        res(achi_pkg::RES_CONNECT);
        hangUp;
        $display("test dialing done");
        regWr(achi_pkg::REG_AUTO, 32'h2);
        linePulse(0, numA);
        chk(ringIndicator, 1'h1);
        linePulse(1, 32'h0);
        chk(ringResult, 1'h1);
        linePulse(2, 32'h0);
        chk(ringIndicator, 1'h0);
        linePulse(0, numA);
        linePulse(1, 32'h0);
        chk(answerReq, 1'h0);
        linePulse(1, 32'h0);
        chk(answerReq, 1'h1);
        chk(ringIndicator, 1'h0);
        u_host.send(8'h55);
        chk(remoteValid, 1'h1);
        chk(remoteChar, 8'h55);
        u_host.escape;
        doCmd(achi_pkg::CMD_RETURN_ONLINE, 4'h0, 32'h0);
        res(achi_pkg::RES_CONNECT);
        regChk(achi_pkg::REG_STATUS, 32'h3, 32'h2);
        hangUp;
        regWr(achi_pkg::REG_AUTO, 32'h0);
        doCmd(achi_pkg::CMD_ANSWER, 4'h0, 32'h0);
        res(achi_pkg::RES_ERROR);
        linePulse(0, numA);
        repeat (3) begin
            linePulse(1, 32'h0);
            chk(answerReq, 1'h0);
        end
        doCmd(achi_pkg::CMD_ANSWER, 4'h0, 32'h0);
        res(achi_pkg::RES_CONNECT);
        chk(answerReq, 1'h1);
        doCmd(achi_pkg::CMD_ESC_HANGUP, 4'h0, 32'h0);
        res(achi_pkg::RES_OK);
        chk(hangupReq, 1'h1);
        regChk(achi_pkg::REG_STATUS, 32'h3, 32'h0);
        $display("test answering done");
        regWr(achi_pkg::REG_DIR1, numA);
        linePulse(0, numA);
        chk(routedPort, 2'h1);
        linePulse(2, 32'h0);
        @(posedge clk);
        portBusy <= 4'h2;
        linePulse(0, numA);
        chk(routedPort, 2'h0);
        linePulse(2, 32'h0);
        @(posedge clk);
        portBusy <= 4'hF;
        linePulse(0, numA);
        chk(busyReject, 1'h1);
        @(posedge clk);
        portBusy <= 4'h0;
        dtr <= 1'h0;
        linePulse(0, numA);
        chk(busyReject, 1'h1);
        regWr(achi_pkg::REG_CFG, 32'h1);
        linePulse(0, numA);
        chk(ringIndicator, 1'h1);
        $display("test steering done");
        report_and_stop;
    end
endmodule // at_call_handling_interpreter_bench
